// ---- src/btd_cond.v ----
// Condition field evaluator against the N, Z, C and V flags.
`timescale 1ns/100ps
`default_nettype none
`include "btd_regs.vh"
module btd_cond (
   input  wire [3:0] cond_i,  // Condition field.
   input  wire [3:0] flags_i, // Flags as N, Z, C, V from bit 3 down.
   output reg        pass_o   // High when the condition holds.
);
   wire n = flags_i[3]; // Negative.
   wire z = flags_i[2]; // Zero.
   wire c = flags_i[1]; // Carry.
   wire v = flags_i[0]; // Overflow.

   // Pairs of codes test a term and its inverse; the reserved code never runs.
   always @* begin
      case (cond_i[3:1])
         3'h0:    pass_o = z;
         3'h1:    pass_o = c;
         3'h2:    pass_o = n;
         3'h3:    pass_o = v;
         3'h4:    pass_o = c & ~z;
         3'h5:    pass_o = (n == v);
         3'h6:    pass_o = ~z & (n == v);
         default: pass_o = 1'b1;
      endcase
      if (cond_i == `BTD_CC_NV) begin
         pass_o = 1'b0;
      end else if (cond_i != `BTD_CC_AL && cond_i[0]) begin
         pass_o = ~pass_o;
      end
   end
endmodule // btd_cond
`default_nettype wire

// ---- src/btd_pick.v ----
// Register list scanner: lowest selected index and count of selected bits.
`timescale 1ns/100ps
`default_nettype none
module btd_pick #(
   parameter W = 16 // Width of the register list.
) (
   input  wire [W-1:0] list_i,  // Remaining selected registers.
   output reg  [3:0]   low_o,   // Index of the lowest set bit.
   output wire [4:0]   count_o  // Number of set bits.
);
   wire [4:0] sum [0:W]; // Running population count.
   assign sum[0] = 5'h00;

   // One adder stage per list bit.
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_cnt
         assign sum[g+1] = sum[g] + {4'h0, list_i[g]};
      end
   endgenerate
   assign count_o = sum[W];

   // Scan from the top down so the lowest set bit is the last to win.
   integer k;
   always @* begin
      low_o = 4'h0;
      for (k = W - 1; k >= 0; k = k - 1) begin
         if (list_i[k]) begin
            low_o = k[3:0];
         end
      end
   end
endmodule // btd_pick
`default_nettype wire

// ---- src/btd_regs.vh ----
// Constants for the block transfer decoder: fields, offsets and values.
//
// Contract
// RQ1: Execute only when condition field passes flags.
// RQ2: List bit n selects register n.
// RQ3: Software never issues an empty register list.
// RQ4: Stored program counter equals instruction address plus 12.
// RQ5: Bit 20 zero stores, one loads.
// RQ6: No write-back keeps base; loads may overwrite.
// RQ7: Bit 22 forces user bank or PSR load.
// RQ8: Bit 23 adds offset when one, subtracts otherwise.
// RQ9: Bit 24 offsets before transfer when one.
// RQ10: Addresses come from base field, P and U.
// RQ11: Registers move in ascending order, PC last.
// RQ12: Lowest register uses lowest block address.
// RQ13: Base low two bits ignored but driven out.
// RQ14: Signed byte and halfword forms are loads only.
// RQ15: Opcode bits 27 to 25 equal 100.
// RQ16: Write-back base moves by four per register.
`ifndef BTD_REGS_VH
`define BTD_REGS_VH

// Instruction fields.
`define BTD_F_COND   31:28
`define BTD_F_OPC    27:25
`define BTD_OPC_BLK  3'h4
`define BTD_B_PRE    24
`define BTD_B_UP     23
`define BTD_B_PSR    22
`define BTD_B_WB     21
`define BTD_B_LOAD   20
`define BTD_F_BASE   19:16
`define BTD_F_LIST   15:0

// Program counter register index and its stored offset.
`define BTD_PC_IDX   4'hF
`define BTD_PC_OFS   32'h0000000C

// Register map, byte addresses.
`define BTD_A_CTRL   8'h00
`define BTD_A_INSTR  8'h04
`define BTD_A_BASE   8'h08
`define BTD_A_IADDR  8'h0C
`define BTD_A_FLAGS  8'h10
`define BTD_A_STAT   8'h14
`define BTD_A_CADDR  8'h18
`define BTD_A_NBASE  8'h1C

// Control bits: start pulse and privileged mode level.
`define BTD_C_START  0
`define BTD_C_PRIV   1

// Status bits.
`define BTD_S_BUSY   0
`define BTD_S_DONE   1
`define BTD_S_SKIP   2
`define BTD_S_BADOP  3

// Condition codes with special meaning.
`define BTD_CC_AL    4'hE
`define BTD_CC_NV    4'hF

`endif

// ---- src/btd_top.v ----
// Block load and block store decoder with address sequencing.
`timescale 1ns/100ps
`default_nettype none
`include "btd_regs.vh"
module btd_top (
   input  wire        REF_CLK_I,      // Core clock, 40 MHz.
   input  wire        ARST_N_I,       // Asynchronous reset, active low.
   input  wire [7:0]  BUS_ADDR_I,     // Register byte address.
   input  wire [31:0] BUS_WDATA_I,    // Register write data.
   input  wire        BUS_WR_I,       // Write strobe.
   input  wire        BUS_RD_I,       // Read strobe.
   output reg  [31:0] BUS_RDATA_O,    // Read data, one cycle after the strobe.
   output reg  [31:0] MEM_ADDR_O,     // Transfer address.
   output reg         MEM_RD_O,       // Memory read strobe for a block load.
   output reg         MEM_WR_O,       // Memory write strobe for a block store.
   output reg  [31:0] MEM_WDATA_O,    // Store data.
   input  wire [31:0] MEM_RDATA_I,    // Load data, cycle after the read strobe.
   output reg         USER_BANK_O,    // Transfers use the user-mode bank.
   output reg  [3:0]  REG_RIDX_O,     // Register file read index.
   input  wire [31:0] REG_RDATA_I,    // Register file read data.
   output reg         REG_WE_O,       // Register file write for loaded data.
   output reg  [3:0]  REG_WIDX_O,     // Register file write index.
   output reg  [31:0] REG_WDATA_O,    // Register file write data.
   output reg         PSR_LOAD_O,     // Saved PSR copied to current PSR.
   output reg         BASE_WE_O,      // Base write-back strobe.
   output reg  [3:0]  BASE_IDX_O,     // Base register index.
   output reg  [31:0] BASE_WDATA_O    // Written-back base value.
);
   // Sequencer states, one-hot.
   localparam [2:0] ST_IDLE  = 3'b001; // Waiting for a start.
   localparam [2:0] ST_ISSUE = 3'b010; // Address and strobe set up.
   localparam [2:0] ST_CAPT  = 3'b100; // Data phase of one word.

   reg  [2:0]  state_q;   // Current state.
   reg  [31:0] instr_q;   // Instruction word under decode.
   reg  [31:0] base_q;    // Starting base register value.
   reg  [31:0] iaddr_q;   // Address of the instruction itself.
   reg  [3:0]  flags_q;   // Condition flags N, Z, C, V.
   reg         priv_q;    // Privileged mode level.
   reg         done_q;    // Last instruction finished.
   reg         skip_q;    // Last instruction failed its condition.
   reg         badop_q;   // Last word was not a block transfer.
   reg  [15:0] left_q;    // Registers still to move.
   reg  [29:0] word_q;    // Word address of the next transfer.
   reg  [31:0] nbase_q;   // Base value after write-back.
   reg         first_q;   // First word of the block still pending.
   reg  [3:0]  cur_q;     // Register of the transfer in flight.

   wire        cond_pass; // Condition holds against the flags.
   wire [3:0]  low_idx;   // Lowest register still to move.
   wire [4:0]  left_cnt;  // Count of registers still to move.
   wire [3:0]  lst_low;   // Lowest register of the new instruction.
   wire [4:0]  lst_cnt;   // Count of registers of the new instruction.

   // Decoded fields of the stored instruction.
   wire        f_pre  = instr_q[`BTD_B_PRE];
   wire        f_up   = instr_q[`BTD_B_UP];
   wire        f_psr  = instr_q[`BTD_B_PSR];
   wire        f_wb   = instr_q[`BTD_B_WB];
   wire        f_load = instr_q[`BTD_B_LOAD];
   wire [15:0] f_list = instr_q[`BTD_F_LIST];

   // Software write decode; start is a one-cycle command.
   wire wr_ctrl  = BUS_WR_I && BUS_ADDR_I == `BTD_A_CTRL;
   wire start    = wr_ctrl && BUS_WDATA_I[`BTD_C_START] && state_q == ST_IDLE;
   wire is_block = instr_q[`BTD_F_OPC] == `BTD_OPC_BLK; // see RQ15

   btd_cond u_cond (
      .cond_i  (instr_q[`BTD_F_COND]),
      .flags_i (flags_q),
      .pass_o  (cond_pass)
   );

   // Scanner for the transfer in progress.
   btd_pick #(.W(16)) u_left (
      .list_i  (left_q),
      .low_o   (low_idx),
      .count_o (left_cnt)
   );

   // Scanner for the instruction about to start.
   btd_pick #(.W(16)) u_list (
      .list_i  (f_list),
      .low_o   (lst_low),
      .count_o (lst_cnt)
   );

   // Block geometry in words. The two low base bits stay out of the sum
   // so a misaligned base never carries into the word address.
   wire [29:0] base_w = base_q[31:2];                       // see RQ13
   wire [29:0] cnt_w  = {25'h0000000, lst_cnt};
   wire [29:0] one_w  = 30'h00000001;
   // Lowest address of the block: ascending blocks start above or at the
   // base, descending blocks start n words (pre) or n-1 words (post) below it.
   wire [29:0] low_w  = f_up ? (f_pre ? base_w + one_w : base_w)  // see RQ8
                             : (f_pre ? base_w - cnt_w           // see RQ9
                                      : base_w - cnt_w + one_w);  // see RQ12
   wire [29:0] end_w  = f_up ? base_w + cnt_w : base_w - cnt_w;   // see RQ16

   // Force the user bank in a privileged mode, except for a load that
   // takes the program counter, which instead copies the saved PSR.
   wire pc_in_list = f_list[`BTD_PC_IDX];
   wire psr_copy   = f_psr && f_load && pc_in_list;               // see RQ7
   // The mode bit that travels in the same write as start is the one that
   // applies, so software may change mode and start with a single write.
   // The stored level would lag one instruction behind.
   wire user_bank  = f_psr && BUS_WDATA_I[`BTD_C_PRIV] && !psr_copy; // see RQ7

   // Configuration registers written by software.
   always @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         instr_q <= 32'h00000000;
         base_q  <= 32'h00000000;
         iaddr_q <= 32'h00000000;
         flags_q <= 4'h0;
         priv_q  <= 1'b0;
      end else if (BUS_WR_I && state_q == ST_IDLE) begin
         // Writes while busy are dropped so the decode stays stable.
         case (BUS_ADDR_I)
            `BTD_A_CTRL:  priv_q  <= BUS_WDATA_I[`BTD_C_PRIV];
            `BTD_A_INSTR: instr_q <= BUS_WDATA_I;
            `BTD_A_BASE:  base_q  <= BUS_WDATA_I;
            `BTD_A_IADDR: iaddr_q <= BUS_WDATA_I;
            `BTD_A_FLAGS: flags_q <= BUS_WDATA_I[3:0];
            default:      priv_q  <= priv_q;
         endcase
      end
   end

   // Transfer sequencer. Each word takes an issue cycle and a data cycle.
   always @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_q      <= ST_IDLE;
         done_q       <= 1'b0;
         skip_q       <= 1'b0;
         badop_q      <= 1'b0;
         left_q       <= 16'h0000;
         word_q       <= 30'h00000000;
         nbase_q      <= 32'h00000000;
         first_q      <= 1'b0;
         cur_q        <= 4'h0;
         MEM_ADDR_O   <= 32'h00000000;
         MEM_RD_O     <= 1'b0;
         MEM_WR_O     <= 1'b0;
         MEM_WDATA_O  <= 32'h00000000;
         USER_BANK_O  <= 1'b0;
         REG_RIDX_O   <= 4'h0;
         REG_WE_O     <= 1'b0;
         REG_WIDX_O   <= 4'h0;
         REG_WDATA_O  <= 32'h00000000;
         PSR_LOAD_O   <= 1'b0;
         BASE_WE_O    <= 1'b0;
         BASE_IDX_O   <= 4'h0;
         BASE_WDATA_O <= 32'h00000000;
      end else begin
         // Strobes default low and are raised for one cycle below.
         MEM_RD_O   <= 1'b0;
         MEM_WR_O   <= 1'b0;
         REG_WE_O   <= 1'b0;
         PSR_LOAD_O <= 1'b0;
         BASE_WE_O  <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  done_q  <= 1'b0;
                  skip_q  <= 1'b0;
                  badop_q <= 1'b0;
                  nbase_q <= {end_w, base_q[1:0]};
                  if (!is_block) begin
                     // Not a block transfer: flag it and do nothing.
                     badop_q <= 1'b1; // see RQ15
                     done_q  <= 1'b1;
                  end else if (!cond_pass) begin
                     // Condition false: the instruction has no effect.
                     skip_q <= 1'b1; // see RQ1
                     done_q <= 1'b1;
                  end else if (f_list == 16'h0000) begin
                     // An empty list is illegal; it is simply retired.
                     done_q <= 1'b1; // see RQ3
                  end else begin
                     left_q      <= f_list;             // see RQ2
                     word_q      <= low_w;              // see RQ10
                     first_q     <= 1'b1;
                     cur_q       <= lst_low;
                     MEM_ADDR_O  <= {low_w, base_q[1:0]}; // see RQ13
                     MEM_RD_O    <= f_load;             // see RQ5
                     REG_RIDX_O  <= lst_low;
                     USER_BANK_O <= user_bank;
                     state_q     <= ST_ISSUE;
                  end
               end
            end
            ST_ISSUE: begin
               // Stores take their data now; the program counter goes out
               // as the instruction address plus twelve.
               if (!f_load) begin
                  MEM_WR_O    <= 1'b1;                  // see RQ5
                  MEM_WDATA_O <= (cur_q == `BTD_PC_IDX) ?
                                 iaddr_q + `BTD_PC_OFS   // see RQ4
                                 : REG_RDATA_I;
               end
               // Write-back lands in the second cycle, so a base stored
               // first goes out unchanged and later loads overwrite it.
               if (first_q && f_wb) begin
                  BASE_WE_O    <= 1'b1;                 // see RQ16
                  BASE_IDX_O   <= instr_q[`BTD_F_BASE];
                  BASE_WDATA_O <= nbase_q;              // see RQ6
               end
               first_q <= 1'b0;
               left_q  <= left_q & ~(16'h0001 << cur_q);
               word_q  <= word_q + one_w;
               state_q <= ST_CAPT;
            end
            ST_CAPT: begin
               // Loaded data is written back to the register file.
               if (f_load) begin
                  REG_WE_O    <= 1'b1;                  // see RQ5
                  REG_WIDX_O  <= cur_q;
                  REG_WDATA_O <= MEM_RDATA_I;           // see RQ6
                  PSR_LOAD_O  <= psr_copy && cur_q == `BTD_PC_IDX;
               end
               if (left_q == 16'h0000) begin
                  // The program counter, when present, is always last.
                  done_q      <= 1'b1;                  // see RQ11
                  USER_BANK_O <= 1'b0;
                  state_q     <= ST_IDLE;
               end else begin
                  // Next register in ascending order at the next word.
                  cur_q      <= low_idx;                // see RQ11
                  MEM_ADDR_O <= {word_q, base_q[1:0]};  // see RQ12
                  MEM_RD_O   <= f_load;
                  REG_RIDX_O <= low_idx;
                  state_q    <= ST_ISSUE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Status word; busy is derived from the state, bits 8 to 4 hold the count of registers left, bits 3 to 1 are flags and bits 31 to 9 read zero.
   wire [31:0] status = {23'h000000, left_cnt, badop_q, skip_q, done_q,
                         state_q != ST_IDLE};

   // Read port: data stands in the cycle after the strobe only.
   always @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         BUS_RDATA_O <= 32'h00000000;
      end else if (BUS_RD_I) begin
         case (BUS_ADDR_I)
            `BTD_A_CTRL:  BUS_RDATA_O <= {30'h00000000, priv_q, 1'b0};
            `BTD_A_INSTR: BUS_RDATA_O <= instr_q;
            `BTD_A_BASE:  BUS_RDATA_O <= base_q;
            `BTD_A_IADDR: BUS_RDATA_O <= iaddr_q;
            `BTD_A_FLAGS: BUS_RDATA_O <= {28'h0000000, flags_q};
            `BTD_A_STAT:  BUS_RDATA_O <= status;
            `BTD_A_CADDR: BUS_RDATA_O <= MEM_ADDR_O;
            `BTD_A_NBASE: BUS_RDATA_O <= nbase_q;
            default:      BUS_RDATA_O <= 32'h00000000;
         endcase
      end else begin
         BUS_RDATA_O <= 32'h00000000;
      end
   end
endmodule // btd_top
`default_nettype wire

// ---- verif/btd_mem_model.sv ----
// Memory partner that answers block loads for the decoder.
`timescale 1ns/100ps
`default_nettype none
module btd_mem_model #(
   parameter logic [31:0] PAT = 32'h3C3C0000 // Pattern mixed into addresses.
) (
   input  wire logic        clk_i,   // Core clock.
   input  wire logic        rd_i,    // Read strobe from the decoder.
   input  wire logic [31:0] addr_i,  // Byte address of the read.
   output var  logic [31:0] rdata_o  // Read data, one cycle after the strobe.
);
   // A word stands only in the cycle after its strobe; afterwards the bus
   // shows the inverse, so a late sample by the core cannot look right.
   always @(posedge clk_i) begin
      if (rd_i) begin
         rdata_o <= addr_i ^ PAT;
      end else begin
         rdata_o <= ~rdata_o;
      end
   end
endmodule // btd_mem_model
`default_nettype wire

// ---- verif/btd_top_sva.sv ----
// Checker for the decoder's memory, register and write-back ports.
`timescale 1ns/100ps
`default_nettype none
`include "btd_regs.vh"
module btd_top_sva (
   input wire logic        REF_CLK_I,
   input wire logic        ARST_N_I,
   input wire logic [7:0]  BUS_ADDR_I,
   input wire logic [31:0] BUS_WDATA_I,
   input wire logic        BUS_WR_I,
   input wire logic [31:0] MEM_ADDR_O,
   input wire logic        MEM_RD_O,
   input wire logic        MEM_WR_O,
   input wire logic [31:0] MEM_WDATA_O,
   input wire logic [31:0] MEM_RDATA_I,
   input wire logic [3:0]  REG_RIDX_O,
   input wire logic        REG_WE_O,
   input wire logic [3:0]  REG_WIDX_O,
   input wire logic [31:0] REG_WDATA_O,
   input wire logic        PSR_LOAD_O,
   input wire logic        BASE_WE_O,
   input wire logic [3:0]  BASE_IDX_O,
   input wire logic [31:0] BASE_WDATA_O
);
   logic [31:0] instr_q, base_q, iaddr_q; // Shadows of software writes.
   logic [31:0] step_w;                   // Four bytes per listed register.
   assign step_w = 4 * $countones(instr_q[15:0]);
   // Shadows follow the bus; software only writes them while idle.
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         instr_q <= 32'h0;
         base_q  <= 32'h0;
         iaddr_q <= 32'h0;
      end else if (BUS_WR_I) begin
         if (BUS_ADDR_I == `BTD_A_INSTR) instr_q <= BUS_WDATA_I;
         if (BUS_ADDR_I == `BTD_A_BASE) base_q <= BUS_WDATA_I;
         if (BUS_ADDR_I == `BTD_A_IADDR) iaddr_q <= BUS_WDATA_I;
      end
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   a_store_dir: assert property (MEM_WR_O |-> !instr_q[`BTD_B_LOAD])
      else $error("store strobe during a load");
   a_load_dir: assert property (MEM_RD_O |-> instr_q[`BTD_B_LOAD])
      else $error("load strobe during a store");
   a_low_bits: assert property ((MEM_RD_O || MEM_WR_O) |->
      MEM_ADDR_O[1:0] == base_q[1:0])
      else $error("address low bits differ from base");
   a_word_step: assert property ((MEM_RD_O || MEM_WR_O) ##2
      (MEM_RD_O || MEM_WR_O) |-> MEM_ADDR_O == $past(MEM_ADDR_O, 2) + 32'h4)
      else $error("next word address not four above");
   a_pc_store: assert property (MEM_WR_O &&
      $past(REG_RIDX_O) == `BTD_PC_IDX |->
      MEM_WDATA_O == iaddr_q + `BTD_PC_OFS)
      else $error("stored counter value wrong");
   a_load_data: assert property (MEM_RD_O |-> ##2
      (REG_WE_O && REG_WDATA_O == $past(MEM_RDATA_I)))
      else $error("loaded word not written to register");
   a_wb_value: assert property (BASE_WE_O |->
      instr_q[`BTD_B_WB] && BASE_IDX_O == instr_q[`BTD_F_BASE] &&
      BASE_WDATA_O == (instr_q[`BTD_B_UP] ?
      base_q + step_w : base_q - step_w))
      else $error("write-back value or index wrong");
   a_wb_once: assert property (BASE_WE_O |=> !BASE_WE_O [*4])
      else $error("base written back twice");
   a_psr_pc: assert property (PSR_LOAD_O |-> REG_WE_O &&
      REG_WIDX_O == `BTD_PC_IDX && instr_q[`BTD_B_PSR])
      else $error("status load without counter load");
   a_pc_last: assert property (REG_WE_O &&
      REG_WIDX_O == `BTD_PC_IDX |=> !REG_WE_O [*4])
      else $error("register written after the counter");
   a_ascending: assert property (REG_WE_O ##2 REG_WE_O |->
      REG_WIDX_O > $past(REG_WIDX_O, 2))
      else $error("register order not ascending");
endmodule // btd_top_sva
bind btd_top btd_top_sva btd_top_sva_inst (.REF_CLK_I(REF_CLK_I),
   .ARST_N_I(ARST_N_I), .BUS_ADDR_I(BUS_ADDR_I), .BUS_WDATA_I(BUS_WDATA_I),
   .BUS_WR_I(BUS_WR_I), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O),
   .MEM_WR_O(MEM_WR_O), .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I),
   .REG_RIDX_O(REG_RIDX_O), .REG_WE_O(REG_WE_O), .REG_WIDX_O(REG_WIDX_O),
   .REG_WDATA_O(REG_WDATA_O), .PSR_LOAD_O(PSR_LOAD_O),
   .BASE_WE_O(BASE_WE_O), .BASE_IDX_O(BASE_IDX_O),
   .BASE_WDATA_O(BASE_WDATA_O));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the block transfer decoder.
`timescale 1ns/100ps
`default_nettype none
`include "btd_regs.vh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   miscompares++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_top;
   localparam logic [31:0] PAT   = 32'h3C3C0000; // Memory data pattern.
   localparam logic [31:0] IADDR = 32'h00002000; // Instruction address.
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  b_addr = 8'h00;
   logic [31:0] b_wdata = 32'h0;
   logic        b_wr = 1'b0;
   logic        b_rd = 1'b0;
   wire  [31:0] b_rdata, m_addr, m_wdata, m_rdata, r_wdata, r_rdata, bs_wdata;
   wire         m_rd, m_wr, ub, r_we, psr, bs_we;
   wire  [3:0]  r_ridx, r_widx, bs_idx;
   int          miscompares = 0, n_checks = 0, n_wb, n_psr, n_ub;
   logic [31:0] wa[$], wd[$], ra[$], lw[$], wb_val;
   logic [3:0]  li[$];
   // Register file: each register holds a value that names it.
   assign r_rdata = {28'hA5A5A5A, r_ridx};
   always #12.5 clk = ~clk;
   btd_top btd_top_inst (.REF_CLK_I(clk), .ARST_N_I(rst_n),
      .BUS_ADDR_I(b_addr), .BUS_WDATA_I(b_wdata), .BUS_WR_I(b_wr),
      .BUS_RD_I(b_rd), .BUS_RDATA_O(b_rdata), .MEM_ADDR_O(m_addr),
      .MEM_RD_O(m_rd), .MEM_WR_O(m_wr), .MEM_WDATA_O(m_wdata),
      .MEM_RDATA_I(m_rdata), .USER_BANK_O(ub), .REG_RIDX_O(r_ridx),
      .REG_RDATA_I(r_rdata), .REG_WE_O(r_we), .REG_WIDX_O(r_widx),
      .REG_WDATA_O(r_wdata), .PSR_LOAD_O(psr), .BASE_WE_O(bs_we),
      .BASE_IDX_O(bs_idx), .BASE_WDATA_O(bs_wdata));
   btd_mem_model #(.PAT(PAT)) btd_mem_model_inst (.clk_i(clk), .rd_i(m_rd),
      .addr_i(m_addr), .rdata_o(m_rdata));
   // Records every transfer; pre-edge values are the ones that stood.
   always @(posedge clk) begin
      if (m_wr) begin
         wa.push_back(m_addr);
         wd.push_back(m_wdata);
      end
      if (m_rd) ra.push_back(m_addr);
      if (r_we) begin
         li.push_back(r_widx);
         lw.push_back(r_wdata);
      end
      if (bs_we) n_wb++;
      if (bs_we) wb_val = bs_wdata;
      if (psr) n_psr++;
      if (ub) n_ub++;
   end
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      b_addr <= a;
      b_wdata <= d;
      b_wr <= 1'b1;
      @(posedge clk);
      b_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic br(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      b_addr <= a;
      b_rd <= 1'b1;
      @(posedge clk);
      b_rd <= 1'b0;
      @(posedge clk);
      d = b_rdata;
   endtask
   // Loads one instruction, starts it and polls for done with a bound.
   task automatic go(input logic [31:0] ins, input logic [31:0] base,
         input logic [3:0] fl, input logic pv, output logic [31:0] st);
      wa.delete(); wd.delete(); ra.delete(); li.delete(); lw.delete();
      n_wb = 0;
      n_psr = 0;
      n_ub = 0;
      wb_val = 32'hX;
      bw(`BTD_A_INSTR, ins);
      bw(`BTD_A_BASE, base);
      bw(`BTD_A_IADDR, IADDR);
      bw(`BTD_A_FLAGS, {28'h0, fl});
      bw(`BTD_A_CTRL, {30'h0, pv, 1'b1});
      st = 32'h0;
      for (int i = 0; i < 60 && st[`BTD_S_DONE] !== 1'b1; i++)
         br(`BTD_A_STAT, st);
      `CHK("done", 1'b1, st[`BTD_S_DONE])
   endtask
   function automatic bit cok(input logic [3:0] c, input logic [3:0] f);
      bit r;
      case (c[3:1])
         3'd0: r = f[2];
         3'd1: r = f[1];
         3'd2: r = f[3];
         3'd3: r = f[0];
         3'd4: r = f[1] & ~f[2];
         3'd5: r = f[3] == f[0];
         3'd6: r = ~f[2] & (f[3] == f[0]);
         default: r = 1'b1;
      endcase
      return (c == 4'hF) ? 1'b0 : (c[0] ? ~r : r);
   endfunction
   // One addressing mode with write-back; base field names register 3.
   task automatic xfer(input logic l, p, u, input logic [15:0] lst,
         input logic [31:0] base);
      logic [31:0] st, a, n4;
      int k;
      n4 = 4 * $countones(lst);
      go({4'hE, 3'b100, p, u, 2'b01, l, 4'h3, lst}, base, 4'h0, 1'b0, st);
      a = u ? (p ? base + 4 : base) : (p ? base - n4 : base - n4 + 4);
      k = 0;
      `CHK("words", $countones(lst), l ? ra.size() : wa.size())
      for (int r = 0; r < 16; r++) if (lst[r]) begin
         if (l) begin
            `CHK("raddr", a, ra[k])
            `CHK("lidx", r[3:0], li[k])
            `CHK("ldata", a ^ PAT, lw[k])
         end else begin
            `CHK("waddr", a, wa[k])
            `CHK("wdata", r == 15 ? IADDR + 32'hC : {28'hA5A5A5A, r[3:0]},
               wd[k])
         end
         a = a + 4;
         k++;
      end
      `CHK("wbval", u ? base + n4 : base - n4, wb_val)
      `CHK("nwb", 1, n_wb)
      br(`BTD_A_NBASE, st);
      `CHK("nbase", u ? base + n4 : base - n4, st)
      br(`BTD_A_CADDR, st);
      `CHK("caddr", a - 4, st)
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      miscompares++;
      complete_run();
   end
   initial begin
      logic [31:0] st;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // All eight load/store, pre/post and up/down combinations.
      for (int m = 0; m < 8; m++)
         xfer(m[2], m[1], m[0], m[2] ? 16'h00AA : 16'h80A2,
            32'h00001002);
      xfer(1'b0, 1'b0, 1'b1, 16'hFFFF, 32'h00001000);
      // Every condition code against two complementary flag sets.
      for (int c = 0; c < 32; c++) begin
         go({c[3:0], 3'b100, 5'b01000, 4'h3, 16'h0001}, 32'h00000100,
            c[4] ? 4'hA : 4'h5, 1'b0, st);
         `CHK("skip", !cok(c[3:0], c[4] ? 4'hA : 4'h5), st[`BTD_S_SKIP])
         `CHK("nstore", cok(c[3:0], c[4] ? 4'hA : 4'h5) ? 1 : 0, wa.size())
      end
      // Every opcode field value: only 100 stores, the other seven are flagged bad.
      for (int o = 0; o < 8; o++) begin
         go({4'hE, o[2:0], 5'b01000, 4'h3, 16'h0001}, 32'h0, 4'h0, 1'b0, st);
         `CHK("badop", o != 4, st[`BTD_S_BADOP])
         `CHK("nstore", o == 4 ? 1 : 0, wa.size())
      end
      // Load without write-back whose list holds the base register.
      go({4'hE, 3'b100, 5'b01001, 4'h3, 16'h0008}, 32'h00000200, 4'h0,
         1'b0, st);
      `CHK("nwb", 0, n_wb)
      `CHK("baseld", 32'h00000200 ^ PAT, lw[0])
      // Forced user bank and status load, privileged and not.
      // The store comes first so in the privileged pass its mode differs from the one before it.
      for (int pv = 0; pv < 2; pv++) begin
         go({4'hE, 3'b100, 5'b01100, 4'h3, 16'h0003}, 32'h00000300, 4'h0,
            pv[0], st);
         `CHK("ubank", pv != 0, n_ub != 0)
         go({4'hE, 3'b100, 5'b01101, 4'h3, 16'h8001}, 32'h00000300, 4'h0,
            pv[0], st);
         `CHK("psrld", 1, n_psr)
         `CHK("noubank", 0, n_ub)
         `CHK("lastpc", `BTD_PC_IDX, li[1])
      end
      br(8'hFC, st);
      `CHK("unmapped", 32'h0, st)
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
